// File: shared/gpio_pkg.sv
// Shared constants and types for the two GPIO ports
package gpio_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 18;           // Byte address width, four bytes per register index
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PORT_A_W = 6;
  localparam int unsigned PORT_B_W = 8;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PORT_A_DATA = 16'hffd6;
  localparam logic [15:0] IDX_PORT_A_DIRECTION = 16'hffe6;
  localparam logic [15:0] IDX_PORT_A_PULLUP_ENABLE = 16'hffee;
  localparam logic [15:0] IDX_PORT_A_FUNCTION_SELECT = 16'hfffd;
  localparam logic [15:0] IDX_SERIAL_CONTROL = 16'hfff0;
  localparam logic [15:0] IDX_PORT_B_DATA = 16'hffd8;
  localparam logic [15:0] IDX_PORT_B_DIRECTION = 16'hffe8;
  localparam logic [15:0] IDX_PORT_B_PULLUP_ENABLE = 16'hffef;

  // ----------------------------------------------------------------
  // Reset values and fixed read values
  // ----------------------------------------------------------------
  localparam logic [5:0] PORT_A_RESET = 6'h00;
  localparam logic [2:0] FSEL_RESET = 3'h0;
  localparam logic [7:0] PORT_B_RESET = 8'h00;
  localparam logic SER_CTRL_RESET = 1'b0;
  localparam logic [7:0] WRITE_ONLY_READ = 8'hff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned FSEL_SERIAL_CLOCK = 0;   // serial_clock_select
  localparam int unsigned FSEL_SERIAL_IN = 1;      // serial_in_select
  localparam int unsigned FSEL_SERIAL_OUT = 2;     // serial_out_select
  localparam int unsigned CTRL_CLOCK_SOURCE = 0;   // serial_clock_source

  // ----------------------------------------------------------------
  // Power modes as driven by the system controller
  // ----------------------------------------------------------------
  localparam logic [2:0] PM_ACTIVE = 3'h0;
  localparam logic [2:0] PM_SUBACTIVE = 3'h1;
  localparam logic [2:0] PM_SLEEP = 3'h2;
  localparam logic [2:0] PM_SUBSLEEP = 3'h3;
  localparam logic [2:0] PM_STANDBY = 3'h4;
  localparam logic [2:0] PM_WATCH = 3'h5;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// File: verilog/pin_sync.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,                 // System clock
  input wire logic rstN,                // Synchronised reset, active low
  input wire logic [WIDTH-1:0] async,   // Levels from the pins
  output logic [WIDTH-1:0] sync         // Levels safe to use
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_q <= '0;
      sync <= '0;
    end else begin
      meta_q <= async;
      sync <= meta_q;
    end
  end

endmodule

// File: verilog/gpio_ports_three_and_five.sv
// GPIO logic for the 6-bit port A with serial pin muxing and the 8-bit port B
//
// Overview of operation
// [RULE1] Port A bits 5..3: direction 0 is input, 1 is output.
// [RULE2] Serial-out select 1 makes bit 2 the serial data output.
// [RULE3] Serial-in select 1 makes bit 1 the serial data input.
// [RULE4] Serial-clock select on bit 0: source 0 clock out, source 1 clock in.
// [RULE5] Port A floats in reset and standby, holds in sleep, works when active.
// [RULE6] In standby a pin with pull-up on is driven high.
// [RULE7] Port A pull-up on only when direction is 0 and pull-up bit 1.
// [RULE8] Port A pull-ups are off after reset.
// [RULE9] Port B has an 8-bit read/write data register.
// [RULE10] Port B data read gives stored bit for outputs, pin level for inputs.
// [RULE11] Port B data register clears to zero on reset.
// [RULE12] Port B direction bit 1 is output, 0 is input.
// [RULE13] Port B direction register clears to zero on reset.
// [RULE14] Port B direction register is write-only and reads all ones.
// [RULE15] Port B input pin pull-up follows its pull-up bit.
// [RULE16] Port B pull-up register clears to zero on reset.
// [RULE17] Port A data read gives stored bit for outputs, pin level for inputs.
// [RULE18] Port A direction and data act only where general I/O is selected.
// [RULE19] Port A function select bits clear on reset.
// [RULE20] General I/O outputs drive stored data; inputs are not driven.
// [RULE21] Port B output pins have their pull-up off.
`timescale 1ns/100ps
module gpio_ports_three_and_five
  import gpio_pkg::*;
(
  input wire logic clk,                        // System clock, 100 MHz
  input wire logic reset_n,                    // Asynchronous reset, active low
  input wire logic [ADDR_W-1:0] wbAdr,         // Wishbone byte address
  input wire logic [DATA_W-1:0] wbDatI,        // Wishbone write data
  output logic [DATA_W-1:0] wbDatO,            // Wishbone read data
  input wire logic [3:0] wbSel,                // Wishbone byte selects
  input wire logic wbWe,                       // Wishbone write enable
  input wire logic wbCyc,                      // Wishbone cycle
  input wire logic wbStb,                      // Wishbone strobe
  output logic wbAck,                          // Wishbone acknowledge
  input wire logic [2:0] powerMode,            // Current power mode
  input wire logic [PORT_A_W-1:0] portAIn,     // Port A pin levels
  output logic [PORT_A_W-1:0] portAOut,        // Port A pin drive value
  output logic [PORT_A_W-1:0] portAOe,         // Port A pin drive enable
  output logic [PORT_A_W-1:0] portAPullup,     // Port A pull-up enable
  input wire logic [PORT_B_W-1:0] portBIn,     // Port B pin levels
  output logic [PORT_B_W-1:0] portBOut,        // Port B pin drive value
  output logic [PORT_B_W-1:0] portBOe,         // Port B pin drive enable
  output logic [PORT_B_W-1:0] portBPullup,     // Port B pull-up enable
  input wire logic serialDataOut,              // Serial transmit data to the pin
  input wire logic serialClkOut,               // Serial clock to the pin
  output logic serialDataIn,                   // Serial receive data from the pin
  output logic serialClkIn                     // Serial clock from the pin
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rstSync_q;
  logic rstN;
  logic [PORT_A_W-1:0] pinA;
  logic [PORT_B_W-1:0] pinB;

  // Release the reset through two flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  pin_sync #(.WIDTH(PORT_A_W)) syncA (
    .clk(clk),
    .rstN(rstN),
    .async(portAIn),
    .sync(pinA)
  );

  pin_sync #(.WIDTH(PORT_B_W)) syncB (
    .clk(clk),
    .rstN(rstN),
    .async(portBIn),
    .sync(pinB)
  );

  // Stored bit where the pin drives, pin level where it listens
  function automatic logic [7:0] readBack(input logic [7:0] data, input logic [7:0] dir,
                                          input logic [7:0] pin);
    readBack = (data & dir) | (pin & ~dir);
  endfunction

  // ----------------------------------------------------------------
  // Register file and bus slave
  // ----------------------------------------------------------------
  logic [PORT_A_W-1:0] dataA_q;
  logic [PORT_A_W-1:0] dirA_q;
  logic [PORT_A_W-1:0] puA_q;
  logic [2:0] fsel_q;
  logic clkSrc_q;
  logic [PORT_B_W-1:0] dataB_q;
  logic [PORT_B_W-1:0] dirB_q;
  logic [PORT_B_W-1:0] puB_q;
  bus_state_t busState_q;
  logic [15:0] idx;
  logic request;
  logic wrLow;
  logic [7:0] rdByte;
  logic rdHit;
  logic [7:0] rdA;

  assign idx = wbAdr[ADDR_W-1:2];
  assign request = wbCyc && wbStb && (busState_q == BUS_IDLE);
  assign wrLow = request && wbWe && wbSel[0];
  assign rdA = readBack({2'b00, dataA_q}, {2'b00, dirA_q}, {2'b00, pinA}); // Port A read mix, top bits unused

  // Read data selection
  always_comb begin
    rdHit = 1'b1;
    rdByte = 8'h00;
    case (idx)
      IDX_PORT_A_DATA: begin
        rdByte = {2'b00, rdA[5:0]}; // [RULE17]
      end
      IDX_PORT_A_DIRECTION: begin
        rdByte = WRITE_ONLY_READ;
      end
      IDX_PORT_A_PULLUP_ENABLE: begin
        rdByte = {2'b00, puA_q};
      end
      IDX_PORT_A_FUNCTION_SELECT: begin
        rdByte = {5'h00, fsel_q};
      end
      IDX_SERIAL_CONTROL: begin
        rdByte = {7'h00, clkSrc_q};
      end
      IDX_PORT_B_DATA: begin
        rdByte = readBack(dataB_q, dirB_q, pinB); // [RULE10]
      end
      IDX_PORT_B_DIRECTION: begin
        rdByte = WRITE_ONLY_READ; // [RULE14]
      end
      IDX_PORT_B_PULLUP_ENABLE: begin
        rdByte = puB_q;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // Single-beat handshake, ack one cycle after the strobe
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busState_q <= BUS_IDLE;
      wbAck <= 1'b0;
      wbDatO <= UNMAPPED_READ;
    end else begin
      case (busState_q)
        BUS_IDLE: begin
          if (wbCyc && wbStb) begin
            busState_q <= BUS_ACK;
            wbAck <= 1'b1;
            wbDatO <= rdHit ? {24'h000000, rdByte} : UNMAPPED_READ;
          end
        end
        BUS_ACK: begin
          busState_q <= BUS_IDLE;
          wbAck <= 1'b0;
        end
        default: begin
          busState_q <= BUS_IDLE;
          wbAck <= 1'b0;
        end
      endcase
    end
  end

  // Port A registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataA_q <= PORT_A_RESET;
      dirA_q <= PORT_A_RESET;
      puA_q <= PORT_A_RESET; // [RULE8]
      fsel_q <= FSEL_RESET; // [RULE19]
      clkSrc_q <= SER_CTRL_RESET;
    end else if (wrLow) begin
      case (idx)
        IDX_PORT_A_DATA: dataA_q <= wbDatI[PORT_A_W-1:0];
        IDX_PORT_A_DIRECTION: dirA_q <= wbDatI[PORT_A_W-1:0];
        IDX_PORT_A_PULLUP_ENABLE: puA_q <= wbDatI[PORT_A_W-1:0];
        IDX_PORT_A_FUNCTION_SELECT: fsel_q <= wbDatI[2:0];
        IDX_SERIAL_CONTROL: clkSrc_q <= wbDatI[CTRL_CLOCK_SOURCE];
        default: begin
        end
      endcase
    end
  end

  // Port B registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      dataB_q <= PORT_B_RESET; // [RULE11]
      dirB_q <= PORT_B_RESET; // [RULE13]
      puB_q <= PORT_B_RESET; // [RULE16]
    end else if (wrLow) begin
      case (idx)
        IDX_PORT_B_DATA: dataB_q <= wbDatI[7:0]; // [RULE9]
        IDX_PORT_B_DIRECTION: dirB_q <= wbDatI[7:0];
        IDX_PORT_B_PULLUP_ENABLE: puB_q <= wbDatI[7:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin function muxing
  // ----------------------------------------------------------------
  logic functional;
  logic holding;
  logic [PORT_A_W-1:0] aOutD;
  logic [PORT_A_W-1:0] aOeD;
  logic [PORT_A_W-1:0] aPuD;
  logic [PORT_B_W-1:0] bPuD;

  assign functional = (powerMode == PM_ACTIVE) || (powerMode == PM_SUBACTIVE);
  assign holding = (powerMode == PM_SLEEP) || (powerMode == PM_SUBSLEEP);
  assign aPuD = ~dirA_q & puA_q; // [RULE7]
  assign bPuD = ~dirB_q & puB_q; // [RULE15] [RULE21]

  // General I/O by default, serial functions override bits 2..0
  always_comb begin
    aOutD = dataA_q; // [RULE20]
    aOeD = dirA_q; // [RULE1] [RULE18]
    if (fsel_q[FSEL_SERIAL_OUT]) begin
      aOutD[2] = serialDataOut; // [RULE2]
      aOeD[2] = 1'b1;
    end
    if (fsel_q[FSEL_SERIAL_IN]) begin
      aOutD[1] = 1'b0; // [RULE3]
      aOeD[1] = 1'b0;
    end
    if (fsel_q[FSEL_SERIAL_CLOCK]) begin
      aOutD[0] = serialClkOut; // [RULE4]
      aOeD[0] = !clkSrc_q;
    end
  end

  // Port A pin drive per power mode
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      portAOut <= PORT_A_RESET; // [RULE5]
      portAOe <= PORT_A_RESET;
      portAPullup <= PORT_A_RESET;
    end else if (functional) begin
      portAOut <= aOutD;
      portAOe <= aOeD;
      portAPullup <= aPuD;
    end else if (!holding) begin
      portAOut <= aPuD; // [RULE6]
      portAOe <= aPuD; // [RULE5]
      portAPullup <= aPuD;
    end
  end

  // Port B pin drive per power mode
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      portBOut <= PORT_B_RESET;
      portBOe <= PORT_B_RESET;
      portBPullup <= PORT_B_RESET;
    end else if (functional) begin
      portBOut <= dataB_q;
      portBOe <= dirB_q; // [RULE12]
      portBPullup <= bPuD;
    end else if (!holding) begin
      portBOut <= bPuD;
      portBOe <= bPuD;
      portBPullup <= bPuD;
    end
  end

  // Serial inputs taken from the synchronised pin levels
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      serialDataIn <= 1'b0;
      serialClkIn <= 1'b0;
    end else begin
      serialDataIn <= pinA[1]; // [RULE3]
      serialClkIn <= pinA[0]; // [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_upper_dir: assert property ( // [RULE1]
    @(posedge clk) disable iff (!rstN)
    functional |=> (portAOe[5:3] == $past(dirA_q[5:3])) && (portAOut[5:3] == $past(dataA_q[5:3])))
    else $error("upper port A pins do not follow direction and data");

  a_serial_out: assert property ( // [RULE2]
    @(posedge clk) disable iff (!rstN)
    (functional && fsel_q[FSEL_SERIAL_OUT]) |=> (portAOe[2] && (portAOut[2] == $past(serialDataOut))))
    else $error("serial data output not on bit 2");

  a_serial_in: assert property ( // [RULE3]
    @(posedge clk) disable iff (!rstN)
    (functional && fsel_q[FSEL_SERIAL_IN]) |=> !portAOe[1])
    else $error("serial input pin is driven");

  a_clock_dir: assert property ( // [RULE4]
    @(posedge clk) disable iff (!rstN)
    (functional && fsel_q[FSEL_SERIAL_CLOCK]) |=> (portAOe[0] == !$past(clkSrc_q)))
    else $error("serial clock pin direction wrong");

  a_standby_float: assert property ( // [RULE6]
    @(posedge clk) disable iff (!rstN)
    (powerMode == PM_STANDBY) |=> ((portAOe == $past(aPuD)) && (portAOut == $past(aPuD))))
    else $error("standby drive does not match pull-ups");

  a_sleep_hold: assert property ( // [RULE5]
    @(posedge clk) disable iff (!rstN)
    holding |=> ($stable(portAOe) && $stable(portAOut) && $stable(portBOe)))
    else $error("pins changed during sleep");

  a_pullup_a: assert property ( // [RULE7]
    @(posedge clk) disable iff (!rstN)
    functional |=> (portAPullup == $past(~dirA_q & puA_q)))
    else $error("port A pull-up gating wrong");

  a_pullup_b: assert property ( // [RULE21]
    @(posedge clk) disable iff (!rstN)
    functional |=> ((portBPullup & $past(dirB_q)) == 8'h00) && (portBPullup == $past(bPuD)))
    else $error("port B pull-up gating wrong");

  a_dir_readback: assert property ( // [RULE14]
    @(posedge clk) disable iff (!rstN)
    (request && !wbWe && (idx == IDX_PORT_B_DIRECTION)) |=> (wbAck && (wbDatO == 32'h0000_00ff)))
    else $error("direction register does not read all ones");

  a_data_readback: assert property ( // [RULE10]
    @(posedge clk) disable iff (!rstN)
    (request && !wbWe && (idx == IDX_PORT_B_DATA))
      |=> (wbDatO[7:0] == (($past(dataB_q) & $past(dirB_q)) | ($past(pinB) & ~$past(dirB_q)))))
    else $error("port B data read mixes wrong sources");

  a_reset_clear: assert property ( // [RULE11]
    @(posedge clk) $rose(rstN) |-> ((dataB_q == 8'h00) && (dirB_q == 8'h00) && (puB_q == 8'h00)
      && (fsel_q == 3'h0) && (portAPullup == 6'h00)))
    else $error("registers not cleared by reset");

endmodule

// File: bench/gpio_board.sv
// Board model resolving the pins of both ports from all drivers
`timescale 1ns/100ps
module gpio_board (
  input wire logic [5:0] portAOut,    // Device drive value, port A
  input wire logic [5:0] portAOe,     // Device drive enable, port A
  input wire logic [5:0] portAPullup, // Device pull-up, port A
  input wire logic [7:0] portBOut,    // Device drive value, port B
  input wire logic [7:0] portBOe,     // Device drive enable, port B
  input wire logic [7:0] portBPullup, // Device pull-up, port B
  input wire logic [5:0] extA,        // Board drive value, port A
  input wire logic [5:0] extEnA,      // Board drive enable, port A
  input wire logic [7:0] extB,        // Board drive value, port B
  input wire logic [7:0] extEnB,      // Board drive enable, port B
  output logic [5:0] portAIn,         // Resolved level, port A
  output logic [7:0] portBIn          // Resolved level, port B
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // Device first, then board, then pull-up; a floating pin shows the
  // inverse of the board value so a stale level never reads back
  assign portAIn = (portAOe & portAOut) | (~portAOe & extEnA & extA) |
                   (~portAOe & ~extEnA & (portAPullup | ~extA));
  assign portBIn = (portBOe & portBOut) | (~portBOe & extEnB & extB) |
                   (~portBOe & ~extEnB & (portBPullup | ~extB));
endmodule

// File: bench/gpio_ports_three_and_five_tb.sv
// Self-checking bench for the two GPIO ports
`timescale 1ns/100ps
module gpio_ports_three_and_five_tb
  import gpio_pkg::*;
;
  typedef struct packed {logic [7:0] dir, dat, pu, ext, rd, pul;} row_t;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] wbAdr = '0;
  logic [DATA_W-1:0] wbDatI = '0;
  logic [DATA_W-1:0] wbDatO;
  logic [3:0] wbSel = 4'h0;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbAck;
  logic [2:0] powerMode = PM_ACTIVE;
  logic [5:0] portAIn, portAOut, portAOe, portAPullup;
  logic [7:0] portBIn, portBOut, portBOe, portBPullup;
  logic serialDataOut = 1'b0;
  logic serialClkOut = 1'b0;
  logic serialDataIn, serialClkIn;
  logic [5:0] extA = 6'h00;
  logic [5:0] extEnA = 6'h3f;
  logic [7:0] extB = 8'h00;
  logic [7:0] extEnB = 8'hff;
  logic [31:0] q;
  int err_total = 0;
  int samples_checked = 0;
  row_t rows [4] = '{'{8'hff, 8'ha5, 8'hff, 8'h00, 8'ha5, 8'h00}, '{8'h00, 8'ha5, 8'hff, 8'h3c, 8'h3c, 8'hff},
                     '{8'h0f, 8'h5a, 8'hf0, 8'hc3, 8'hca, 8'hf0}, '{8'hf0, 8'h81, 8'h0f, 8'h7e, 8'h8e, 8'h0f}};

  gpio_ports_three_and_five i_gpio_ports_three_and_five (.clk(clk), .reset_n(reset_n), .wbAdr(wbAdr),
    .wbDatI(wbDatI), .wbDatO(wbDatO), .wbSel(wbSel), .wbWe(wbWe), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck),
    .powerMode(powerMode), .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe), .portAPullup(portAPullup),
    .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe), .portBPullup(portBPullup),
    .serialDataOut(serialDataOut), .serialClkOut(serialClkOut), .serialDataIn(serialDataIn),
    .serialClkIn(serialClkIn));
  gpio_board i_gpio_board (.portAOut(portAOut), .portAOe(portAOe), .portAPullup(portAPullup),
    .portBOut(portBOut), .portBOe(portBOe), .portBPullup(portBPullup), .extA(extA), .extEnA(extEnA),
    .extB(extB), .extEnB(extEnB), .portAIn(portAIn), .portBIn(portBIn));

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    err_total++;
    results();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // One classic cycle, held until ack is sampled high
  task automatic wbXfer(input logic [15:0] idx, input logic we, input logic [7:0] d, input logic [3:0] sel);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbDatI <= {24'h000000, d};
    wbSel <= sel;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    wbXfer(idx, 1'b1, d, 4'h1);
  endtask
  task automatic rd(input logic [15:0] idx);
    wbXfer(idx, 1'b0, 8'h00, 4'hf);
  endtask
  // Lets the pin registers and the input synchroniser catch up
  task automatic settle();
    repeat (5) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    check(portAOe, 32'h0);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    foreach (rows[i]) begin
      extB <= rows[i].ext;
      wr(IDX_PORT_B_DIRECTION, rows[i].dir);
      wr(IDX_PORT_B_DATA, rows[i].dat);
      wr(IDX_PORT_B_PULLUP_ENABLE, rows[i].pu);
      settle();
      check(portBOe, rows[i].dir);
      check(portBOut & portBOe, rows[i].dat & rows[i].dir);
      check(portBPullup, rows[i].pul);
      rd(IDX_PORT_B_DATA);
      check(q, rows[i].rd);
      rd(IDX_PORT_B_PULLUP_ENABLE);
      check(q, rows[i].pu);
      rd(IDX_PORT_B_DIRECTION);
      check(q, 32'hff);
    end
    // Board lets go: an input pin with pull-up reads high
    @(posedge clk);
    extEnB <= 8'h00;
    extB <= 8'hff;
    wr(IDX_PORT_B_DIRECTION, 8'h00);
    wr(IDX_PORT_B_PULLUP_ENABLE, 8'hf0);
    settle();
    rd(IDX_PORT_B_DATA);
    check(q, 32'hf0);
    // Port A as general I/O
    wr(IDX_PORT_A_DIRECTION, 8'h3f);
    wr(IDX_PORT_A_DATA, 8'h2a);
    settle();
    check(portAOe, 32'h3f);
    check(portAOut, 32'h2a);
    @(posedge clk);
    extA <= 6'h2b;
    wr(IDX_PORT_A_DIRECTION, 8'h07);
    wr(IDX_PORT_A_PULLUP_ENABLE, 8'h3f);
    settle();
    rd(IDX_PORT_A_DATA);
    check(q, 32'h2a);
    check(portAPullup, 32'h38);
    // Serial functions override the direction bits
    @(posedge clk);
    serialDataOut <= 1'b1;
    serialClkOut <= 1'b1;
    wr(IDX_PORT_A_FUNCTION_SELECT, 8'h07);
    wr(IDX_SERIAL_CONTROL, 8'h00);
    settle();
    check(portAOe & 6'h07, 32'h5);
    check(portAOut & 6'h05, 32'h5);
    check(serialDataIn, 32'h1);
    @(posedge clk);
    serialDataOut <= 1'b0;
    serialClkOut <= 1'b0;
    wr(IDX_SERIAL_CONTROL, 8'h01);
    settle();
    check(portAOe & 6'h07, 32'h4);
    check(portAOut & 6'h04, 32'h0);
    check(serialClkIn, 32'h1);
    // Sleep modes freeze the pins; standby drives pulled-up pins high
    foreach (rows[m]) begin
      @(posedge clk);
      powerMode <= (m < 2) ? PM_SLEEP + 3'(m) : PM_STANDBY + 3'(m - 2);
      settle();
      if (m < 2) begin
        wr(IDX_PORT_A_DIRECTION, 8'h3f);
        settle();
        check(portAOe, 32'h04);
        wr(IDX_PORT_A_DIRECTION, 8'h07);
      end else begin
        check(portAOe, 32'h38);
        check(portAOut, 32'h38);
        check(portBOe, 32'hf0);
      end
      powerMode <= PM_SUBACTIVE;
      settle();
      check(portAOe, 32'h04);
    end
    // Ignored byte lane, unmapped index
    wr(IDX_PORT_A_FUNCTION_SELECT, 8'h00);
    wbXfer(IDX_PORT_A_DATA, 1'b1, 8'hff, 4'h0);
    rd(IDX_PORT_A_DATA);
    check(q, 32'h2a);
    rd(16'h1234);
    check(q, UNMAPPED_READ);
    // Reset in mid-run
    reset_n <= 1'b0;
    @(negedge clk);
    check(portAOe, 32'h0);
    check(portBPullup, 32'h0);
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    check(portAPullup, 32'h0);
    check(portBOe, 32'h0);
    rd(IDX_PORT_B_PULLUP_ENABLE);
    check(q, 32'h0);
    rd(IDX_PORT_A_FUNCTION_SELECT);
    check(q, 32'h0);
    wr(IDX_PORT_B_DIRECTION, 8'hff);
    rd(IDX_PORT_B_DATA);
    check(q, 32'h0);
    results();
  end
endmodule
